// ==== include/egpio_pkg.sv ====
package egpio_pkg;
  // ------------------------------------------------------------
  // Register map (word addresses on a byte-addressed bus)
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFS_LATCH = 6'h00;
  localparam logic [5:0] OFS_DIR = 6'h04;
  localparam logic [5:0] OFS_PULLUP = 6'h08;
  localparam logic [5:0] OFS_INBUF = 6'h0c;
  localparam logic [5:0] OFS_OTYPE = 6'h10;
  localparam logic [5:0] OFS_RDSRC = 6'h14;
  localparam logic [5:0] OFS_PINS = 6'h18;
  // ------------------------------------------------------------
  // Reset values and implemented-bit masks
  // ------------------------------------------------------------
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_INBUF = 8'h00;
  localparam logic [7:0] RST_OTYPE = 8'h00;
  localparam logic RST_RDSRC = 1'b0;
  localparam logic [7:0] MASK_INBUF = 8'he1;
  localparam logic [7:0] MASK_OTYPE = 8'ha1;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
  // ------------------------------------------------------------
  // Bus slave states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {EGPIO_IDLE, EGPIO_ACK, EGPIO_DONE} egpio_bus_e;
endpackage

// ==== design/egpio_sync.sv ====
`timescale 1ns/1ps
module egpio_sync #(
  parameter int WIDTH = 8
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] st1_reg;
  logic [WIDTH-1:0] st2_reg;
  logic [WIDTH-1:0] st3_reg;
  logic [WIDTH-1:0] out_reg;

  // First stage feeds only the second
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      st1_reg <= '0;
      st2_reg <= '0;
      st3_reg <= '0;
    end else begin
      st1_reg <= async_in;
      st2_reg <= st1_reg;
      st3_reg <= st2_reg;
    end
  end

  // Change accepted once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
          out_reg[g] <= 1'b0;
        end else if (st2_reg[g] == st3_reg[g]) begin
          out_reg[g] <= st3_reg[g];
        end
      end
    end
  endgenerate

  assign sync_out = out_reg;
endmodule // egpio_sync

// ==== design/egpio_port.sv ====
`timescale 1ns/1ps
module egpio_port
  import egpio_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [egpio_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [WIDTH-1:0] PIN_IN,
  input wire logic [WIDTH-1:0] ALT_OUT,
  output logic [WIDTH-1:0] PIN_OUT,
  output logic [WIDTH-1:0] PIN_OE,
  output logic [WIDTH-1:0] PULLUP_ON,
  output logic [WIDTH-1:0] TTL_SELECT
);
  import egpio_pkg::*;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [WIDTH-1:0] port_latch_reg;
  logic [WIDTH-1:0] direction_reg;
  logic [WIDTH-1:0] pullup_enable_reg;
  logic [WIDTH-1:0] input_buffer_select_reg;
  logic [WIDTH-1:0] output_type_select_reg;
  logic read_source_select;
  logic [WIDTH-1:0] pin_sync;
  egpio_bus_e bus_reg;
  logic [31:0] rdata_reg;
  logic wait_reg;
  logic [WIDTH-1:0] pin_out_reg;
  logic [WIDTH-1:0] pin_oe_reg;
  logic [WIDTH-1:0] pullup_reg;
  logic [WIDTH-1:0] ttl_reg;
  logic [WIDTH-1:0] drive_val;
  logic [WIDTH-1:0] oe_next;
  logic [WIDTH-1:0] port_read;
  logic wr_take;
  logic rd_take;

  function automatic logic [WIDTH-1:0] merge_lane(input logic [WIDTH-1:0] old_v,
                                                   input logic [31:0] wd,
                                                   input logic [3:0] be,
                                                   input logic [WIDTH-1:0] mask);
    logic [WIDTH-1:0] r;
    r = old_v;
    if (be[0]) begin
      r = wd[WIDTH-1:0] & mask;
    end
    return r;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] ofs);
    return a == ofs;
  endfunction

  egpio_sync #(.WIDTH(WIDTH)) u_sync (
    .CLK_SYS(CLK_SYS),
    .RSTN(RSTN),
    .async_in(PIN_IN),
    .sync_out(pin_sync)
  );

  // ------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, answer on the following edge
  // ------------------------------------------------------------
  assign wr_take = (bus_reg == EGPIO_ACK) && AVS_WRITE;
  assign rd_take = (bus_reg == EGPIO_ACK) && AVS_READ;

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      bus_reg <= EGPIO_IDLE;
      wait_reg <= 1'b1;
    end else begin
      unique case (bus_reg)
        EGPIO_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            bus_reg <= EGPIO_ACK;
            wait_reg <= 1'b0;
          end
        end
        EGPIO_ACK: begin
          bus_reg <= EGPIO_DONE;
          wait_reg <= 1'b1;
        end
        EGPIO_DONE: begin
          bus_reg <= EGPIO_IDLE;
        end
        default: begin
          bus_reg <= EGPIO_IDLE;
          wait_reg <= 1'b1;
        end
      endcase
    end
  end

  // Read data prepared while waitrequest is still high
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      rdata_reg <= UNMAPPED_DATA;
    end else if (bus_reg == EGPIO_IDLE && AVS_READ) begin
      rdata_reg <= UNMAPPED_DATA;
      if (hit(AVS_ADDRESS, OFS_LATCH)) begin
        rdata_reg[WIDTH-1:0] <= port_read;
      end else if (hit(AVS_ADDRESS, OFS_DIR)) begin
        rdata_reg[WIDTH-1:0] <= direction_reg;
      end else if (hit(AVS_ADDRESS, OFS_PULLUP)) begin
        rdata_reg[WIDTH-1:0] <= pullup_enable_reg;
      end else if (hit(AVS_ADDRESS, OFS_INBUF)) begin
        rdata_reg[WIDTH-1:0] <= input_buffer_select_reg;
      end else if (hit(AVS_ADDRESS, OFS_OTYPE)) begin
        rdata_reg[WIDTH-1:0] <= output_type_select_reg;
      end else if (hit(AVS_ADDRESS, OFS_RDSRC)) begin
        rdata_reg[0] <= read_source_select;
      end else if (hit(AVS_ADDRESS, OFS_PINS)) begin
        rdata_reg[WIDTH-1:0] <= pin_sync;
      end
    end
  end

  // Pin level is readable in open-drain mode while read_source_select is 0; at 1, output bits read the latch
  assign port_read = (direction_reg & pin_sync)
                   | (~direction_reg & (read_source_select ? port_latch_reg : pin_sync));

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      port_latch_reg <= RST_LATCH;
    end else if (wr_take && hit(AVS_ADDRESS, OFS_LATCH)) begin
      port_latch_reg <= merge_lane(port_latch_reg, AVS_WRITEDATA, AVS_BYTEENABLE, '1);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      direction_reg <= RST_DIR;
    end else if (wr_take && hit(AVS_ADDRESS, OFS_DIR)) begin
      direction_reg <= merge_lane(direction_reg, AVS_WRITEDATA, AVS_BYTEENABLE, '1);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pullup_enable_reg <= RST_PULLUP;
    end else if (wr_take && hit(AVS_ADDRESS, OFS_PULLUP)) begin
      pullup_enable_reg <= merge_lane(pullup_enable_reg, AVS_WRITEDATA, AVS_BYTEENABLE, '1);
    end
  end

  // Unimplemented option bits stay zero: bits 1..4 fixed CMOS, bits 1..4 and 6 fixed push-pull
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      input_buffer_select_reg <= RST_INBUF;
      output_type_select_reg <= RST_OTYPE;
    end else if (wr_take) begin
      if (hit(AVS_ADDRESS, OFS_INBUF)) begin
        input_buffer_select_reg <= merge_lane(input_buffer_select_reg, AVS_WRITEDATA,
                                              AVS_BYTEENABLE, MASK_INBUF);
      end
      if (hit(AVS_ADDRESS, OFS_OTYPE)) begin
        output_type_select_reg <= merge_lane(output_type_select_reg, AVS_WRITEDATA,
                                             AVS_BYTEENABLE, MASK_OTYPE);
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      read_source_select <= RST_RDSRC;
    end else if (wr_take && hit(AVS_ADDRESS, OFS_RDSRC) && AVS_BYTEENABLE[0]) begin
      read_source_select <= AVS_WRITEDATA[0];
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  // Alternate outputs OR in; software parks them at 0 for plain port use
  assign drive_val = port_latch_reg | ALT_OUT;
  // Open-drain drives only a low level; high means released
  assign oe_next = ~direction_reg & ~(output_type_select_reg & drive_val);

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pin_out_reg <= '0;
      pin_oe_reg <= '0;
      pullup_reg <= '0;
      ttl_reg <= '0;
    end else begin
      pin_out_reg <= drive_val;
      pin_oe_reg <= oe_next;
      pullup_reg <= pullup_enable_reg & direction_reg;
      ttl_reg <= input_buffer_select_reg;
    end
  end

  assign PIN_OUT = pin_out_reg;
  assign PIN_OE = pin_oe_reg;
  assign PULLUP_ON = pullup_reg;
  assign TTL_SELECT = ttl_reg;
  assign AVS_READDATA = rdata_reg;
  assign AVS_WAITREQUEST = wait_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_req_wait;
    (AVS_READ || AVS_WRITE) && bus_reg == EGPIO_IDLE;
  endsequence
  sequence s_ack;
    ##1 !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence

  bus_answer_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    s_req_wait |-> s_ack) else $error("bus answer not in one cycle");
  reset_input_a: assert property (@(posedge CLK_SYS)
    !RSTN |=> direction_reg == 8'hff && PIN_OE == 8'h00) else $error("reset not input");
  latch_write_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    wr_take && AVS_ADDRESS == OFS_LATCH && AVS_BYTEENABLE[0]
    |=> port_latch_reg == $past(AVS_WRITEDATA[7:0])) else $error("latch not written");
  input_no_drive_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ##1 ((PIN_OE & $past(direction_reg)) == 8'h00)) else $error("input bit driven");
  pullup_gate_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ##1 PULLUP_ON == ($past(pullup_enable_reg) & $past(direction_reg)))
    else $error("pull-up wrong");
  inbuf_mask_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (input_buffer_select_reg & 8'h1e) == 8'h00) else $error("buffer option on bits 1-4");
  otype_mask_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (output_type_select_reg & 8'h5e) == 8'h00) else $error("output type on bad bit");
  open_drain_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ##1 ((PIN_OE & $past(output_type_select_reg) & $past(drive_val)) == 8'h00))
    else $error("open drain drives high");
  read_source_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    AVS_READ && bus_reg == EGPIO_IDLE && AVS_ADDRESS == OFS_LATCH
    |=> rdata_reg[7:0] == $past(port_read)) else $error("port read wrong");

  // ------------------------------------------------------------
  // Bus timing and read path checks
  // ------------------------------------------------------------
  // Dead cycle after every answer keeps back-to-back requests apart
  sequence s_dead;
    AVS_WAITREQUEST ##1 bus_reg == EGPIO_IDLE;
  endsequence
  sequence s_port_read;
    AVS_READ && bus_reg == EGPIO_IDLE && AVS_ADDRESS == OFS_LATCH;
  endsequence

  dead_cycle_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (rd_take || wr_take) |=> s_dead) else $error("no dead cycle after answer");
  read_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !(AVS_READ && bus_reg == EGPIO_IDLE) |=> $stable(AVS_READDATA))
    else $error("read data changed without a read");
  input_read_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    s_port_read |=> ((rdata_reg[7:0] ^ $past(pin_sync)) & $past(direction_reg)) == 8'h00)
    else $error("input bit not read from pin");
  pin_source_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    s_port_read ##0 !read_source_select |=> rdata_reg[7:0] == $past(pin_sync))
    else $error("pin level not returned");
  latch_source_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    s_port_read ##0 read_source_select
    |=> ((rdata_reg[7:0] ^ $past(port_latch_reg)) & ~$past(direction_reg)) == 8'h00)
    else $error("output bit not read from latch");

  // ------------------------------------------------------------
  // Pin drive and register checks
  // ------------------------------------------------------------
  pushpull_drive_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ##1 ((~PIN_OE & ~$past(direction_reg) & ~$past(output_type_select_reg)) == 8'h00))
    else $error("push-pull output bit not driven");
  output_value_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ##1 (((PIN_OUT ^ $past(port_latch_reg)) & ~$past(direction_reg) & ~$past(ALT_OUT)) == 8'h00))
    else $error("output bit not from latch");
  reset_pins_a: assert property (@(posedge CLK_SYS)
    !RSTN |=> PIN_OUT == 8'h00 && PULLUP_ON == 8'h00 && TTL_SELECT == 8'h00
    && AVS_WAITREQUEST) else $error("outputs not idle after reset");
  lane_off_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    wr_take && !AVS_BYTEENABLE[0] |=> $stable(port_latch_reg))
    else $error("latch written with lane off");
  dir_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    !(wr_take && AVS_ADDRESS == OFS_DIR) |=> $stable(direction_reg))
    else $error("direction changed without write");
endmodule // egpio_port

// ==== verification/egpio_pin_model.sv ====
`timescale 1ns/1ps
module egpio_pin_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_on,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in,
  output logic [7:0] alt_out
);
  // Undriven pins without pull-up sit on a board pull-down
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
                  (~pin_oe & ~ext_en & pullup_on);
  // Alternate peripherals idle so the latch owns the pins
  assign alt_out = 8'h00;
endmodule // egpio_pin_model

// ==== verification/eight_bit_gpio_port_one_tb.sv ====
`timescale 1ns/1ps
module eight_bit_gpio_port_one_tb;
  import egpio_pkg::*;
  logic CLK_SYS, RSTN, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [5:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
  logic [3:0] AVS_BYTEENABLE;
  logic [7:0] PIN_IN, ALT_OUT, PIN_OUT, PIN_OE, PULLUP_ON, TTL_SELECT, ext_en, ext_val;
  int n_errors, n_compared;

  egpio_port u_egpio_port (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIN_IN(PIN_IN), .ALT_OUT(ALT_OUT),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PULLUP_ON(PULLUP_ON), .TTL_SELECT(TTL_SELECT));
  egpio_pin_model u_egpio_pin_model (.pin_out(PIN_OUT), .pin_oe(PIN_OE),
    .pullup_on(PULLUP_ON), .ext_en(ext_en), .ext_val(ext_val), .pin_in(PIN_IN),
    .alt_out(ALT_OUT));

  // ------------------------------------------------------------
  // Bus access and compare helpers
  // ------------------------------------------------------------
  task automatic test_done;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge; the watchdog ends a hang
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h000000, d};
    do begin
      @(posedge CLK_SYS);
    end while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(negedge CLK_SYS);
  endtask

  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h000000, e});
  endtask

  // Synchroniser needs about four edges before pins show up in reads
  task automatic settle;
    repeat (6) @(negedge CLK_SYS);
  endtask

  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end

  initial begin
    #20000;
    n_errors++;
    test_done;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    n_errors = 0;
    n_compared = 0;
    RSTN = 1'b0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 6'h00;
    AVS_WRITEDATA = 32'h00000000;
    AVS_BYTEENABLE = 4'h1;
    ext_en = 8'h00;
    ext_val = 8'h00;
    repeat (4) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    settle;
    chk(PIN_OE, 8'h00);
    rchk(OFS_DIR, RST_DIR);
    rchk(OFS_PULLUP, RST_PULLUP);
    rchk(OFS_INBUF, RST_INBUF);
    rchk(OFS_OTYPE, RST_OTYPE);
    rchk(OFS_LATCH, 8'h00);
    rchk(6'h1c, 8'h00);
    bus(1'b1, OFS_PULLUP, 8'hff);
    bus(1'b1, OFS_LATCH, 8'ha5);
    bus(1'b1, OFS_DIR, 8'h0f);
    settle;
    chk(PIN_OE, 8'hf0);
    chk(PIN_OUT & 8'hf0, 8'ha0);
    chk(PULLUP_ON, 8'h0f);
    rchk(OFS_PINS, 8'haf);
    bus(1'b1, OFS_INBUF, 8'hff);
    rchk(OFS_INBUF, MASK_INBUF);
    chk(TTL_SELECT, MASK_INBUF);
    bus(1'b1, OFS_OTYPE, 8'hff);
    rchk(OFS_OTYPE, MASK_OTYPE);
    // Open-drain bits released high, held low from outside
    ext_en <= MASK_OTYPE;
    bus(1'b1, OFS_LATCH, 8'hff);
    bus(1'b1, OFS_DIR, 8'h00);
    settle;
    chk(PIN_OE, {24'h000000, ~MASK_OTYPE});
    chk(PULLUP_ON, 8'h00);
    rchk(OFS_PINS, 8'h5e);
    rchk(OFS_LATCH, 8'h5e);
    bus(1'b1, OFS_RDSRC, 8'h01);
    rchk(OFS_LATCH, 8'hff);
    bus(1'b1, OFS_DIR, 8'h01);
    settle;
    rchk(OFS_LATCH, 8'hfe);
    // Lane 0 off: write must leave the latch alone
    @(posedge CLK_SYS);
    AVS_BYTEENABLE <= 4'h0;
    bus(1'b1, OFS_LATCH, 8'h00);
    @(posedge CLK_SYS);
    AVS_BYTEENABLE <= 4'h1;
    rchk(OFS_LATCH, 8'hfe);
    test_done;
  end
endmodule // eight_bit_gpio_port_one_tb
